// >>> design/cmr_cmd_regs.sv
// Remote command settings register block of the capacitance meter, an AHB-Lite slave.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
module cmr_cmd_regs #(
	parameter int CYC_PER_MS = cmr_pkg::CYC_PER_MS
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic trig_in,
	input wire cmr_pkg::cmr_span_req_t span_req,
	output cmr_pkg::cmr_cfg_t cfg_o,
	output logic term_nonzero_o,
	output logic meas_start_o
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (CYC_PER_MS < 2 || CYC_PER_MS > 65535)
	begin : g_bad_cyc
		$error("CYC_PER_MS must lie in 2..65535");
	end

	typedef enum logic {BUS_IDLE, BUS_DATA} cmr_bus_t;

	typedef struct packed {
		cmr_bus_t bus;
		logic [7:0] addr;
		logic wr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		cmr_pkg::cmr_cfg_t cfg;
		logic hdr_on;
		logic [13:0] wait_lo;
		logic [13:0] wait_hi;
		logic [7:0] term;
		logic term_nz;
		logic cmd_err;
		logic [cmr_pkg::SLOTS-1:0] slot_valid;
		logic q_hit;
		cmr_pkg::cmr_cfg_t q_cfg;
		logic trg_m;
		logic trg_s;
		logic trg_d;
		logic waiting;
		logic [13:0] ms_left;
		logic [15:0] cyc;
		logic meas_start;
	} cmr_state_t;

	cmr_state_t s_r;
	cmr_state_t s_nxt;
	cmr_pkg::cmr_cfg_t panel_mem [cmr_pkg::SLOTS];
	logic mem_we;
	logic [6:0] mem_idx;
	logic wr_ok;
	logic wr_bad;
	logic rd_go;

	localparam logic [15:0] CYC_LAST = 16'(CYC_PER_MS - 1);

	// Round an 8.8 fixed point argument to the nearest integer, 9 bits wide.
	function automatic logic [8:0] rnd(input logic [31:0] v);
		logic [8:0] r;
		r = {1'b0, v[cmr_pkg::NUM_MSB:cmr_pkg::NUM_LSB]} + {8'h00, v[cmr_pkg::NUM_HALF]};
		if (v[31:cmr_pkg::NUM_TOP] != 16'h0000)
		begin
			r = 9'h1FF;
		end
		return r;
	endfunction

	// Span legality depends on the present measurement frequency.
	function automatic logic span_ok(input logic [8:0] sp, input logic mhz);
		logic ok;
		ok = mhz ? (sp >= cmr_pkg::SPAN_HI_MIN && sp <= cmr_pkg::SPAN_HI_MAX)
			: (sp >= cmr_pkg::SPAN_LO_MIN && sp <= cmr_pkg::SPAN_LO_MAX);
		return ok;
	endfunction

	// Small spans mean high impedance, where the parallel model fits best.
	function automatic logic opt_par(input logic [4:0] sp);
		return sp <= cmr_pkg::PAR_MAX_SPAN;
	endfunction

	// Full scale as mantissa (10, 22 or 47) and power of ten in femtofarads.
	function automatic logic [31:0] fscale(input logic [4:0] sp);
		logic [4:0] p;
		logic [7:0] mant;
		logic [7:0] expo;
		p = sp - 5'h01;
		unique case (p % 5'h03)
			5'h00: mant = 8'h16;
			5'h01: mant = 8'h2F;
			default: mant = 8'h0A;
		endcase
		expo = {3'h0, 5'h01 + (p + 5'h01) / 5'h03};
		return {16'h0000, expo, mant};
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// One combinational process decides the whole next state.
	always_comb
	begin
		logic [8:0] r;
		logic [6:0] idx;
		logic [31:0] rd;
		logic slot_in;
		r = rnd(hwdata);
		idx = 7'(r - cmr_pkg::SLOT_MIN);
		slot_in = r >= cmr_pkg::SLOT_MIN && r <= cmr_pkg::SLOT_MAX;
		rd = 32'h0000_0000;
		s_nxt = s_r;
		s_nxt.meas_start = 1'b0;
		mem_we = 1'b0;
		mem_idx = idx;
		wr_ok = 1'b0;
		wr_bad = 1'b0;
		rd_go = 1'b0;

		// Trigger pin synchroniser; the second and third stages feed the edge detector.
		s_nxt.trg_m = trig_in;
		s_nxt.trg_s = s_r.trg_m;
		s_nxt.trg_d = s_r.trg_s;

		if (s_r.waiting)
		begin
			if (s_r.cyc == CYC_LAST)
			begin
				s_nxt.cyc = 16'h0000;
				s_nxt.ms_left = s_r.ms_left - 14'h0001;
				if (s_r.ms_left == 14'h0001)
				begin
					s_nxt.waiting = 1'b0;
					s_nxt.meas_start = 1'b1;
				end
			end
			else
			begin
				s_nxt.cyc = s_r.cyc + 16'h0001;
			end
		end
		else if (s_r.trg_s && !s_r.trg_d)
		begin
			s_nxt.ms_left = s_r.cfg.freq_mhz ? s_r.wait_hi : s_r.wait_lo;
			s_nxt.cyc = 16'h0000;
			// A trigger while a wait runs is ignored; a zero wait starts at once.
			if (s_r.cfg.sso_en && s_nxt.ms_left != 14'h0000)
			begin
				s_nxt.waiting = 1'b1;
			end
			else
			begin
				s_nxt.meas_start = 1'b1;
			end
		end

		// Automatic span choice from the measurement engine
		if (span_req.valid && s_r.cfg.span_auto && span_ok({4'h0, span_req.span}, s_r.cfg.freq_mhz))
		begin
			s_nxt.cfg.span = span_req.span;
			if (s_r.cfg.circ_auto)
			begin
				s_nxt.cfg.circ_par = opt_par(span_req.span);
			end
		end

		// Bus slave: one wait state, then write or load read data.
		unique case (s_r.bus)
			BUS_IDLE:
			begin
				if (hsel && htrans[1] && hready)
				begin
					s_nxt.bus = BUS_DATA;
					s_nxt.addr = haddr[7:0];
					s_nxt.wr = hwrite;
					s_nxt.hreadyout = 1'b0;
				end
			end
			BUS_DATA:
			begin
				s_nxt.bus = BUS_IDLE;
				s_nxt.hreadyout = 1'b1;
				if (s_r.wr)
				begin
					wr_ok = 1'b1;
					unique case (s_r.addr)
						cmr_pkg::OFF_CTRL:
						begin
							if (hwdata[cmr_pkg::CTRL_PRESET])
							begin
								s_nxt.cfg = cmr_pkg::CFG_PRESET;
								s_nxt.term = cmr_pkg::TERM_PRESET;
								s_nxt.term_nz = 1'b0;
								s_nxt.wait_lo = cmr_pkg::WAIT_PRESET;
								s_nxt.wait_hi = cmr_pkg::WAIT_PRESET;
								s_nxt.hdr_on = 1'b1;
							end
							else
							begin
								s_nxt.hdr_on = hwdata[cmr_pkg::CTRL_HDR];
								s_nxt.cfg.freq_mhz = hwdata[cmr_pkg::CTRL_FREQ];
								// Clamp span into the new frequency's set
								if (hwdata[cmr_pkg::CTRL_FREQ] && s_r.cfg.span > 5'(cmr_pkg::SPAN_HI_MAX))
								begin
									s_nxt.cfg.span = 5'(cmr_pkg::SPAN_HI_MAX);
								end
								else if (!hwdata[cmr_pkg::CTRL_FREQ] && s_r.cfg.span < 5'(cmr_pkg::SPAN_LO_MIN))
								begin
									s_nxt.cfg.span = 5'(cmr_pkg::SPAN_LO_MIN);
								end
								// Auto circuit follows a clamped span too
								// A clamp moves the span, so a stale circuit choice would no longer fit it.
								if (s_r.cfg.circ_auto)
								begin
									s_nxt.cfg.circ_par = opt_par(s_nxt.cfg.span);
								end
							end
						end
						cmr_pkg::OFF_SPAN:
						begin
							// Rounded argument checked against span limits
							if (span_ok(r, s_r.cfg.freq_mhz))
							begin
								s_nxt.cfg.span = r[4:0];
								s_nxt.cfg.span_auto = 1'b0;
								if (s_r.cfg.circ_auto)
								begin
									s_nxt.cfg.circ_par = opt_par(r[4:0]);
								end
							end
							else
							begin
								wr_bad = 1'b1;
							end
						end
						cmr_pkg::OFF_AUTO:
						begin
							// Auto span and circuit mode switches
							s_nxt.cfg.span_auto = hwdata[cmr_pkg::AUTO_SPAN];
							s_nxt.cfg.circ_auto = hwdata[cmr_pkg::AUTO_CIRC];
							s_nxt.cfg.circ_par = hwdata[cmr_pkg::AUTO_CIRC] ? opt_par(s_r.cfg.span)
								: hwdata[cmr_pkg::AUTO_PAR];
						end
						cmr_pkg::OFF_SAVE:
						begin
							// Store present conditions in a slot
							if (slot_in)
							begin
								mem_we = 1'b1;
								s_nxt.slot_valid[idx] = 1'b1;
							end
							else
							begin
								wr_bad = 1'b1;
							end
						end
						cmr_pkg::OFF_SAVEQ:
						begin
							// Latch the occupancy of the asked slot
							if (slot_in)
							begin
								s_nxt.q_hit = s_r.slot_valid[idx];
								s_nxt.q_cfg = panel_mem[idx];
							end
							else
							begin
								wr_bad = 1'b1;
							end
						end
						cmr_pkg::OFF_CLEAR:
						begin
							// Erase one slot or all of them
							if (hwdata[cmr_pkg::CLEAR_ALL])
							begin
								s_nxt.slot_valid = '0;
							end
							else if (slot_in)
							begin
								s_nxt.slot_valid[idx] = 1'b0;
							end
							else
							begin
								wr_bad = 1'b1;
							end
						end
						cmr_pkg::OFF_SPEED:
						begin
							if (hwdata[31:2] == 30'h0000_0000 && hwdata[1:0] != cmr_pkg::SPD_BAD)
							begin
								s_nxt.cfg.speed = hwdata[1:0];
							end
							else
							begin
								wr_bad = 1'b1;
							end
						end
						cmr_pkg::OFF_SYNC:
						begin
							s_nxt.cfg.sso_en = hwdata[0];
						end
						cmr_pkg::OFF_WAIT_LO, cmr_pkg::OFF_WAIT_HI:
						begin
							// Wait stored in milliseconds per frequency
							if (hwdata[31:cmr_pkg::WAIT_MSB+1] == 18'h00000
								&& hwdata[cmr_pkg::WAIT_MSB:0] <= cmr_pkg::WAIT_MAX_MS)
							begin
								if (s_r.addr == cmr_pkg::OFF_WAIT_LO)
								begin
									s_nxt.wait_lo = hwdata[cmr_pkg::WAIT_MSB:0];
								end
								else
								begin
									s_nxt.wait_hi = hwdata[cmr_pkg::WAIT_MSB:0];
								end
							end
							else
							begin
								wr_bad = 1'b1;
							end
						end
						cmr_pkg::OFF_TERM:
						begin
							// Terminator class follows zero or nonzero
							if (r <= cmr_pkg::TERM_MAX)
							begin
								s_nxt.term = r[7:0];
								s_nxt.term_nz = r[7:0] != 8'h00;
							end
							else
							begin
								wr_bad = 1'b1;
							end
						end
						cmr_pkg::OFF_STAT:
						begin
							// Write one to clear; a new error below still wins.
							if (hwdata[cmr_pkg::STAT_ERR])
							begin
								s_nxt.cmd_err = 1'b0;
							end
						end
						default:
						begin
							wr_ok = 1'b0;
						end
					endcase
					// Rejected argument raises the error flag
					if (wr_bad)
					begin
						wr_ok = 1'b0;
						s_nxt.cmd_err = 1'b1;
					end
				end
				else
				begin
					rd_go = 1'b1;
					unique case (s_r.addr)
						cmr_pkg::OFF_CTRL: rd = {29'h0, s_r.cfg.freq_mhz, s_r.hdr_on, 1'b0};
						cmr_pkg::OFF_SPAN: rd = {27'h0, s_r.cfg.span};
						cmr_pkg::OFF_AUTO: rd = {29'h0, s_r.cfg.circ_par, s_r.cfg.circ_auto, s_r.cfg.span_auto};
						// Panel query answer never has the header flag
						cmr_pkg::OFF_SAVEQ: rd = {31'h0, s_r.q_hit};
						cmr_pkg::OFF_SPEED: rd = {30'h0, s_r.cfg.speed};
						cmr_pkg::OFF_SYNC: rd = {31'h0, s_r.cfg.sso_en};
						cmr_pkg::OFF_WAIT_LO: rd = {18'h0, s_r.wait_lo};
						cmr_pkg::OFF_WAIT_HI: rd = {18'h0, s_r.wait_hi};
						// Terminator reads as 0 or 1
						cmr_pkg::OFF_TERM: rd = {31'h0, s_r.term_nz};
						cmr_pkg::OFF_STAT: rd = {30'h0, s_r.waiting, s_r.cmd_err};
						cmr_pkg::OFF_PANEL: rd = {20'h0, s_r.q_cfg};
						// Full-scale capacitance of the present span
						cmr_pkg::OFF_FSCALE: rd = fscale(s_r.cfg.span);
						default: rd = 32'h0000_0000;
					endcase
					if (s_r.addr inside {cmr_pkg::OFF_SPAN, cmr_pkg::OFF_AUTO, cmr_pkg::OFF_SPEED,
						cmr_pkg::OFF_SYNC, cmr_pkg::OFF_WAIT_LO, cmr_pkg::OFF_WAIT_HI, cmr_pkg::OFF_TERM})
					begin
						rd[cmr_pkg::RESP_HDR] = s_r.hdr_on;
					end
					s_nxt.hrdata = rd;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	// All control state resets to the preset values.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r <= '{bus: BUS_IDLE, hreadyout: 1'b1, cfg: cmr_pkg::CFG_PRESET, hdr_on: 1'b1,
				term: cmr_pkg::TERM_PRESET, wait_lo: cmr_pkg::WAIT_PRESET,
				wait_hi: cmr_pkg::WAIT_PRESET, default: '0};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// Panel store memory; no reset, occupancy is tracked by slot_valid.
	always_ff @(posedge hclk)
	begin
		if (mem_we)
		begin
			panel_mem[mem_idx] <= s_r.cfg;
		end
	end

	assign hrdata = s_r.hrdata;
	assign hreadyout = s_r.hreadyout;
	assign hresp = s_r.hresp;
	assign cfg_o = s_r.cfg;
	assign term_nonzero_o = s_r.term_nz;
	assign meas_start_o = s_r.meas_start;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic is_span_wr;
	assign is_span_wr = wr_ok && s_r.addr == cmr_pkg::OFF_SPAN;

	a_span_legal: assert property (span_ok({4'h0, s_r.cfg.span}, s_r.cfg.freq_mhz))
		else $error("span outside the set for the present frequency");
	a_span_auto_off: assert property (
		is_span_wr |=> !s_r.cfg.span_auto
		&& s_r.cfg.span == $past(hwdata[cmr_pkg::NUM_LSB+4:cmr_pkg::NUM_LSB])
		+ $past(5'(hwdata[cmr_pkg::NUM_HALF])))
		else $error("span write did not land or left auto span on");
	a_circ_follow: assert property (
		is_span_wr && s_r.cfg.circ_auto
		|=> s_r.cfg.circ_par == (s_r.cfg.span <= cmr_pkg::PAR_MAX_SPAN))
		else $error("circuit not optimal after span write");
	a_preset_vals: assert property (
		wr_ok && s_r.addr == cmr_pkg::OFF_CTRL && hwdata[cmr_pkg::CTRL_PRESET]
		|=> s_r.cfg == cmr_pkg::CFG_PRESET && !s_r.term_nz && s_r.hdr_on)
		else $error("preset did not restore settings");
	a_speed_code: assert property (s_r.cfg.speed != cmr_pkg::SPD_BAD)
		else $error("illegal rate code held");
	a_term_read: assert property (
		rd_go && s_r.addr == cmr_pkg::OFF_TERM
		|=> hrdata[30:0] == {30'h0, s_r.term != 8'h00})
		else $error("terminator query not 0 or 1");
	a_saveq_nohdr: assert property (
		rd_go && s_r.addr == cmr_pkg::OFF_SAVEQ |=> !hrdata[cmr_pkg::RESP_HDR])
		else $error("panel query carried header flag");
	a_hdr_prefix: assert property (
		rd_go && s_r.addr == cmr_pkg::OFF_SPEED |=> hrdata[cmr_pkg::RESP_HDR] == s_r.hdr_on)
		else $error("header flag wrong on rate query");
	a_reject_keep: assert property (
		wr_bad |=> s_r.cmd_err && $stable(s_r.cfg) && $stable(s_r.term))
		else $error("rejected write changed a setting");
	a_wait_range: assert property (
		s_r.wait_lo <= cmr_pkg::WAIT_MAX_MS && s_r.wait_hi <= cmr_pkg::WAIT_MAX_MS)
		else $error("wait beyond 9.999 s");
	a_bus_wait: assert property (
		s_r.bus == BUS_IDLE && hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
		else $error("bus answer not after one wait state");

	c_span_write: cover property (is_span_wr ##1 s_r.cfg.circ_par);
	c_reject: cover property (wr_bad);
	c_wait_done: cover property (s_r.waiting ##[1:1000] meas_start_o);
	c_saveq_hit: cover property (rd_go && s_r.addr == cmr_pkg::OFF_SAVEQ && s_r.q_hit);

endmodule

// >>> design/cmr_pkg.sv
// Package of constants and carrier types for the capacitance meter remote command settings block.
package cmr_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the AHB-Lite bus
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SPAN = 8'h04;
	localparam logic [7:0] OFF_AUTO = 8'h08;
	localparam logic [7:0] OFF_SAVE = 8'h0C;
	localparam logic [7:0] OFF_SAVEQ = 8'h10;
	localparam logic [7:0] OFF_CLEAR = 8'h14;
	localparam logic [7:0] OFF_SPEED = 8'h18;
	localparam logic [7:0] OFF_SYNC = 8'h1C;
	localparam logic [7:0] OFF_WAIT_LO = 8'h20;
	localparam logic [7:0] OFF_WAIT_HI = 8'h24;
	localparam logic [7:0] OFF_TERM = 8'h28;
	localparam logic [7:0] OFF_STAT = 8'h2C;
	localparam logic [7:0] OFF_PANEL = 8'h30;
	localparam logic [7:0] OFF_FSCALE = 8'h34;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_PRESET = 0;
	localparam int CTRL_HDR = 1;
	localparam int CTRL_FREQ = 2;
	localparam int AUTO_SPAN = 0;
	localparam int AUTO_CIRC = 1;
	localparam int AUTO_PAR = 2;
	localparam int CLEAR_ALL = 16;
	localparam int STAT_ERR = 0;
	localparam int STAT_BUSY = 1;
	localparam int RESP_HDR = 31;
	localparam int NUM_LSB = 8;
	localparam int NUM_MSB = 15;
	localparam int NUM_HALF = 7;
	localparam int NUM_TOP = 16;
	localparam int WAIT_MSB = 13;

	// ----------------------------------------------------------------
	// Legal ranges and codes
	// ----------------------------------------------------------------
	localparam logic [8:0] SPAN_LO_MIN = 9'h009;
	localparam logic [8:0] SPAN_LO_MAX = 9'h018;
	localparam logic [8:0] SPAN_HI_MIN = 9'h001;
	localparam logic [8:0] SPAN_HI_MAX = 9'h00C;
	localparam logic [8:0] SLOT_MIN = 9'h001;
	localparam logic [8:0] SLOT_MAX = 9'h046;
	localparam int SLOTS = 70;
	localparam logic [8:0] TERM_MAX = 9'h0FF;
	localparam logic [13:0] WAIT_MAX_MS = 14'h270F;
	localparam logic [4:0] PAR_MAX_SPAN = 5'h0C;
	localparam logic [1:0] SPD_FAST = 2'h0;
	localparam logic [1:0] SPD_NORMAL = 2'h1;
	localparam logic [1:0] SPD_SLOW = 2'h2;
	localparam logic [1:0] SPD_BAD = 2'h3;

	// ----------------------------------------------------------------
	// Timing: the wait counts in milliseconds of the bus clock
	// ----------------------------------------------------------------
	localparam int WAIT_UNIT_NS = 1000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CYC_PER_MS = WAIT_UNIT_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic freq_mhz;
		logic [4:0] span;
		logic span_auto;
		logic circ_auto;
		logic circ_par;
		logic [1:0] speed;
		logic sso_en;
	} cmr_cfg_t;

	typedef struct packed {
		logic valid;
		logic [4:0] span;
	} cmr_span_req_t;

	// Initialized state reached by the preset command and by hresetn.
	localparam cmr_cfg_t CFG_PRESET = '{freq_mhz: 1'b0, span: 5'h0C, span_auto: 1'b1,
		circ_auto: 1'b1, circ_par: 1'b1, speed: SPD_NORMAL, sso_en: 1'b0};
	localparam logic [7:0] TERM_PRESET = 8'h00;
	localparam logic [13:0] WAIT_PRESET = 14'h0000;

endpackage

// >>> dv/cmr_host.sv
// Host computer model: single-word AHB-Lite master for the settings block.
`timescale 1ns/1ns
module cmr_host (
	input wire logic hclk,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// The bus is idle from time zero, so nothing is requested during reset.
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// host chooses spans
	// Spans outside the legal range are only sent when the bench asks for a refusal.
	// The address phase is held until hready is sampled high, then the data phase likewise.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
endmodule

// >>> dv/testbench.sv
// Self-checking testbench of the remote command settings block.
`timescale 1ns/1ns
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic trig_in = 1'b0;
	cmr_pkg::cmr_span_req_t span_req = '0;
	logic hsel, hwrite, hreadyout, hresp, term_nz, meas_start;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	cmr_pkg::cmr_cfg_t cfg_o;
	int fail_count = 0;
	int check_count = 0;
	int n;
	logic [15:0] lf = 16'h000B;
	logic [4:0] es = 5'h0C;
	logic [31:0] hb = 32'h8000_0000;

	// Free-running 10 MHz bus clock.
	always #50 hclk = ~hclk;

	cmr_host HOST (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	cmr_cmd_regs #(.CYC_PER_MS(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.trig_in(trig_in), .span_req(span_req), .cfg_o(cfg_o), .term_nonzero_o(term_nz),
		.meas_start_o(meas_start));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic span_ok(input logic f, input int s);
		return f ? (s >= 1 && s <= 12) : (s >= 9 && s <= 24);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		HOST.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		HOST.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	// A span write; a refused one leaves the span where it was.
	task automatic try_span(input logic f, input int s);
		wr(cmr_pkg::OFF_SPAN, 32'(s) << 8);
		if (span_ok(f, s))
			es = 5'(s);
		rd(cmr_pkg::OFF_SPAN, hb | {27'h0, es});
		chk({31'h0, cfg_o.circ_par}, {31'h0, es <= 5'h0C});
	endtask

	// Counts cycles from a trigger pulse to the start of measurement.
	task automatic trigger;
		trig_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
			if (n == 2)
				trig_in <= 1'b0;
		end
		while (meas_start !== 1'b1 && n < 200);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 20000 cycles.
	initial
	begin
		#2000000;
		fail_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({20'h0, cfg_o}, {20'h0, cmr_pkg::CFG_PRESET});
		rd(cmr_pkg::OFF_CTRL, 32'h2);
		rd(cmr_pkg::OFF_TERM, hb);
		chk({31'h0, hresp}, 32'h0);
		$display("test reset done");
		for (int s = 7; s <= 26; s++)
			try_span(1'b0, s);
		chk({31'h0, cfg_o.span_auto}, 32'h0);
		wr(cmr_pkg::OFF_SPAN, 32'h0000_1480);
		es = 5'd21;
		rd(cmr_pkg::OFF_SPAN, hb | 32'd21);
		wr(cmr_pkg::OFF_STAT, 32'h1);
		wr(cmr_pkg::OFF_SPAN, 32'h0000_1900);
		rd(cmr_pkg::OFF_STAT, 32'h1);
		wr(cmr_pkg::OFF_STAT, 32'h1);
		rd(cmr_pkg::OFF_STAT, 32'h0);
		repeat (24)
		begin
			lf = lfsr(lf);
			try_span(1'b0, int'(lf[4:0]));
		end
		rd(cmr_pkg::OFF_SPAN, hb | {27'h0, es});
		$display("test span 1kHz done");
		wr(cmr_pkg::OFF_AUTO, 32'h3);
		span_req <= '{valid: 1'b1, span: 5'd10};
		repeat (3) @(posedge hclk);
		span_req <= '0;
		@(posedge hclk);
		chk({27'h0, cfg_o.span}, 32'd10);
		rd(cmr_pkg::OFF_AUTO, hb | 32'h7);
		wr(cmr_pkg::OFF_SPAN, 32'h0000_1400);
		rd(cmr_pkg::OFF_AUTO, hb | 32'h2);
		wr(cmr_pkg::OFF_CTRL, 32'h6);
		es = 5'h0C;
		rd(cmr_pkg::OFF_CTRL, 32'h6);
		for (int s = 0; s <= 13; s++)
			try_span(1'b1, s);
		try_span(1'b1, 1);
		rd(cmr_pkg::OFF_FSCALE, 32'h0116);
		try_span(1'b1, 5);
		rd(cmr_pkg::OFF_FSCALE, 32'h022F);
		$display("test span 1MHz done");
		wr(cmr_pkg::OFF_SAVE, 32'h0500);
		wr(cmr_pkg::OFF_SAVEQ, 32'h0500);
		rd(cmr_pkg::OFF_SAVEQ, 32'h1);
		rd(cmr_pkg::OFF_PANEL, {20'h0, 1'b1, es, 6'b011010});
		wr(cmr_pkg::OFF_SAVEQ, 32'h0600);
		rd(cmr_pkg::OFF_SAVEQ, 32'h0);
		wr(cmr_pkg::OFF_SAVE, 32'h4600);
		wr(cmr_pkg::OFF_CLEAR, 32'h0500);
		wr(cmr_pkg::OFF_SAVEQ, 32'h0500);
		rd(cmr_pkg::OFF_SAVEQ, 32'h0);
		wr(cmr_pkg::OFF_SAVEQ, 32'h4600);
		rd(cmr_pkg::OFF_SAVEQ, 32'h1);
		wr(cmr_pkg::OFF_CLEAR, 32'h0001_0000);
		wr(cmr_pkg::OFF_SAVEQ, 32'h4600);
		rd(cmr_pkg::OFF_SAVEQ, 32'h0);
		$display("test panels done");
		for (int k = 0; k < 4; k++)
		begin
			wr(cmr_pkg::OFF_SPEED, 32'(k));
			rd(cmr_pkg::OFF_SPEED, hb | ((k == 3) ? 32'h2 : 32'(k)));
		end
		wr(cmr_pkg::OFF_TERM, 32'h0000_0080);
		rd(cmr_pkg::OFF_TERM, hb | 32'h1);
		chk({31'h0, term_nz}, 32'h1);
		wr(cmr_pkg::OFF_TERM, 32'h0);
		chk({31'h0, term_nz}, 32'h0);
		wr(cmr_pkg::OFF_TERM, 32'h0000_FF80);
		rd(cmr_pkg::OFF_TERM, hb);
		wr(cmr_pkg::OFF_TERM, 32'h0000_FF00);
		rd(cmr_pkg::OFF_TERM, hb | 32'h1);
		$display("test rate and terminator done");
		wr(cmr_pkg::OFF_SYNC, 32'h1);
		rd(cmr_pkg::OFF_SYNC, hb | 32'h1);
		wr(cmr_pkg::OFF_WAIT_HI, 32'h2);
		wr(cmr_pkg::OFF_WAIT_HI, 32'h2710);
		rd(cmr_pkg::OFF_WAIT_HI, hb | 32'h2);
		trigger();
		chk({31'h0, n >= 8 && n <= 20}, 32'h1);
		wr(cmr_pkg::OFF_CTRL, 32'h2);
		trigger();
		chk({31'h0, n >= 3 && n <= 7}, 32'h1);
		try_span(1'b0, 24);
		rd(cmr_pkg::OFF_FSCALE, 32'h090A);
		wr(cmr_pkg::OFF_CTRL, 32'h0);
		hb = 32'h0;
		rd(cmr_pkg::OFF_SPAN, 32'd24);
		$display("test trigger and header done");
		wr(cmr_pkg::OFF_CTRL, 32'h1);
		chk({20'h0, cfg_o}, {20'h0, cmr_pkg::CFG_PRESET});
		chk({31'h0, term_nz}, 32'h0);
		rd(cmr_pkg::OFF_WAIT_HI, 32'h8000_0000);
		$display("test preset done");
		summarize();
	end
endmodule
